// *** include/edx_pkg.sv ***
// Types shared by the auxiliary timing block
package edx_pkg;

  typedef enum logic [1:0] {
    EDX_IN_TRIGGER,
    EDX_IN_LEVEL,
    EDX_IN_MASK,
    EDX_IN_CAPTURE
  } edx_in_fn_t;

  typedef enum logic [1:0] {
    EDX_OUT_DIVCLK,
    EDX_OUT_MARKER,
    EDX_OUT_SYNC,
    EDX_OUT_ERROR
  } edx_out_fn_t;

  typedef enum logic [1:0] {
    EDX_WB_IDLE,
    EDX_WB_ACK
  } edx_wb_state_t;

endpackage : edx_pkg

// *** include/edx_regs.svh ***
// Register offsets, field positions, reset values and limits of the auxiliary timing block
// Functional notes
// R1: Aux input aligns burst reception timing
// R2: Trigger edge opens window of programmed length
// R3: Level gate: data valid while input high
// R4: Mask mode: low input suspends measurement
// R5: External capture: aux input starts capture
// R6: Divided clock locked to pattern start
// R7: Divide ratio even, 4 to 512 only
// R8: One marker pulse per pattern period
// R9: Single lane: marker position in 8-bit steps
// R10: Dual lane: marker position in 16-bit steps
// R11: Mixed patterns: marker spans whole block period
// R12: Single lane: short pattern multiplied to 512
// R13: Dual lane: short pattern multiplied to 1024
// R14: Sync output high while sync established
// R15: Error output high when error found
// R16: Window length 12800 to 2147483392, 256 steps
// R17: Source leaves 512-bit gap, doubled dual
// R18: One input and one output function active
`ifndef EDX_REGS_SVH
`define EDX_REGS_SVH

`define EDX_ADR_CTRL 8'h00
`define EDX_ADR_WINDOW 8'h04
`define EDX_ADR_DIVIDE 8'h08
`define EDX_ADR_MARK_LO 8'h0C
`define EDX_ADR_MARK_HI 8'h10
`define EDX_ADR_PATLEN 8'h14
`define EDX_ADR_STATUS 8'h18

`define EDX_CTRL_IN_LSB 0
`define EDX_CTRL_OUT_LSB 4
`define EDX_CTRL_DUAL_BIT 8
`define EDX_CTRL_CAPEXT_BIT 9
`define EDX_CTRL_MIXED_BIT 10

`define EDX_CTRL_RST 32'h0000_0000
`define EDX_WINDOW_MIN 32'h0000_3200
`define EDX_WINDOW_MAX 32'h7FFF_FF00
`define EDX_WINDOW_STEP_MASK 32'h0000_00FF
`define EDX_DIVIDE_RST 10'h004
`define EDX_DIVIDE_MIN 10'h004
`define EDX_DIVIDE_MAX 10'h200
`define EDX_MARK_MAX_SINGLE 36'h7_FFFF_FEF9
`define EDX_MARK_MAX_DUAL 37'hF_FFFF_FDF1
`define EDX_MARK_RST 37'h0_0000_0001
`define EDX_LANE_GRAN 37'h0_0000_0080
`define EDX_MARK_SUB_SINGLE 37'h0_0000_0087
`define EDX_MARK_SUB_DUAL 37'h0_0000_010F
`define EDX_MIN_PAT_SINGLE 37'h0_0000_0200
`define EDX_MIN_PAT_DUAL 37'h0_0000_0400
`define EDX_PATLEN_RST 32'h0000_0200

`endif

// *** verification/edx_aux_io_assertions.sv ***
// Port-level assertions of the auxiliary timing block
`timescale 1ns/1ps
`include "edx_regs.svh"
module edx_aux_io_assertions
  import edx_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Pins and core
  input wire logic aux_in_i,
  input wire logic aux_out_o,
  input wire logic sync_ok_i,
  input wire logic bit_err_i,
  input wire logic data_valid_o,
  input wire logic meas_en_o,
  input wire logic cap_start_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  edx_in_fn_t in_q;
  edx_out_fn_t out_q;
  logic cap_q;
  logic [2:0] quiet_q;
  logic req;
  logic calm;
  assign req = wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == `EDX_ADR_CTRL);
  assign calm = (quiet_q == 3'h7);
  // Shadow of the function fields
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_q <= EDX_IN_TRIGGER;
      out_q <= EDX_OUT_DIVCLK;
      cap_q <= 1'b0;
    end
    else if (req && wb_ack_o)
    begin
      if (wb_sel_i[0])
      begin
        in_q <= edx_in_fn_t'(wb_dat_i[1:0]);
        out_q <= edx_out_fn_t'(wb_dat_i[5:4]);
      end
      if (wb_sel_i[1])
        cap_q <= wb_dat_i[9];
    end
  end
  // Checks pause after a mode change, the synchroniser still holds old samples
  always_ff @(posedge clk_i)
  begin
    if (rst_i || req)
      quiet_q <= 3'h0;
    else if (!calm)
      quiet_q <= quiet_q + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_trig_rise: assert property (calm && in_q == EDX_IN_TRIGGER && $rose(data_valid_o)
    |-> $past(aux_in_i, 3) && !$past(aux_in_i, 4)) else $error("window open without edge");
  a_level_gate: assert property (calm && in_q == EDX_IN_LEVEL
    |-> data_valid_o == $past(aux_in_i, 3)) else $error("valid not following pin");
  a_mask_follow: assert property (calm && in_q == EDX_IN_MASK
    |-> meas_en_o == $past(aux_in_i, 3)) else $error("mask not following pin");
  a_cap_edge: assert property (calm && in_q == EDX_IN_CAPTURE && cap_q
    |-> cap_start_o == ($past(aux_in_i, 3) && !$past(aux_in_i, 4)))
    else $error("capture start wrong");
  a_sync_out: assert property (calm && out_q == EDX_OUT_SYNC
    |-> aux_out_o == $past(sync_ok_i)) else $error("sync output wrong");
  a_err_out: assert property (calm && out_q == EDX_OUT_ERROR
    |-> aux_out_o == $past(bit_err_i)) else $error("error output wrong");
endmodule : edx_aux_io_assertions

// *** verification/edx_aux_partner.sv ***
// Model of the test set driving the auxiliary input pin
`timescale 1ns/1ps
module edx_aux_partner (
  // Clock
  input wire logic clk_i,
  // Pin
  output logic aux_o
);
  initial aux_o = 1'b0;
  // Holds the pin at a level for a number of cycles
  task automatic hold(input logic lvl, input int n);
    @(posedge clk_i);
    aux_o <= lvl;
    repeat (n - 1) @(posedge clk_i);
  endtask : hold
  // Burst edge then the shortest legal disable gap
  task automatic burst(input int hi, input bit dual);
    hold(1'b1, hi);
    hold(1'b0, dual ? 1024 : 512);
  endtask : burst
endmodule : edx_aux_partner

// *** verification/tb_edx_aux_io.sv ***
// Self-checking bench of the auxiliary timing block
`timescale 1ns/1ps
`include "edx_regs.svh"
`define CHK(a, e) \
  begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module tb_edx_aux_io;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pat = 1'b0, sync = 1'b0, err = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rd, dat_o;
  logic ack, aux, aux_out, dv, men, cap;
  int n_mismatch = 0;
  int n_tests = 0;
  int hi, ri;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
  logic [31:0] rv [7] = '{32'h0, 32'h3200, 32'h4, 32'h1, 32'h0, 32'h200, 32'h0};
  edx_aux_partner partner (.clk_i(clk_i), .aux_o(aux));
  edx_aux_io dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .aux_in_i(aux), .aux_out_o(aux_out), .pat_start_i(pat),
    .sync_ok_i(sync), .bit_err_i(err), .data_valid_o(dv), .meas_en_o(men),
    .cap_start_o(cap));
  initial
    forever #2 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // Counts high cycles and rises of one watched output
  task automatic watch(input int n, input int s);
    logic v, p;
    hi = 0;
    ri = 0;
    p = 1'b1;
    repeat (n)
    begin
      @(posedge clk_i);
      v = (s == 0) ? dv : (s == 1) ? !men : (s == 2) ? cap : aux_out;
      hi += (v === 1'b1);
      ri += (v === 1'b1 && p !== 1'b1);
      p = v;
    end
  endtask : watch
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      wb(1'b0, ra[i], 32'h0);
      `CHK(rd, rv[i])
    end
    wb(1'b1, `EDX_ADR_WINDOW, 32'h0000_0100);
    wb(1'b1, `EDX_ADR_WINDOW, 32'h0000_3280);
    wb(1'b0, `EDX_ADR_WINDOW, 32'h0);
    `CHK(rd, 32'h0000_3200)
    wb(1'b1, `EDX_ADR_WINDOW, 32'h0000_3300);
    fork
      partner.burst(20, 1'b0);
      watch(13200, 0);
    join
    `CHK(hi, 13056)
    `CHK(ri, 1)
    wb(1'b1, `EDX_ADR_CTRL, 32'h0000_0001);
    fork
      begin
        partner.hold(1'b1, 100);
        partner.hold(1'b0, 10);
      end
      watch(130, 0);
    join
    `CHK(hi, 100)
    wb(1'b1, `EDX_ADR_CTRL, 32'h0000_0002);
    partner.hold(1'b1, 20);
    fork
      begin
        partner.hold(1'b0, 50);
        partner.hold(1'b1, 10);
      end
      watch(70, 1);
    join
    `CHK(hi, 50)
    wb(1'b1, `EDX_ADR_CTRL, 32'h0000_0203);
    fork
      begin
        partner.hold(1'b0, 4);
        partner.burst(5, 1'b0);
      end
      watch(600, 2);
    join
    `CHK(ri, 1)
    `CHK(hi, 1)
    for (int k = 0; k < 4; k++)
    begin
      wb(1'b1, `EDX_ADR_CTRL, (k < 2) ? 32'h0000_0020 : 32'h0000_0030);
      @(posedge clk_i);
      sync <= (k == 0);
      err <= (k == 2);
      repeat (4) @(posedge clk_i);
      `CHK(aux_out, (k == 0 || k == 2))
    end
    wb(1'b1, `EDX_ADR_DIVIDE, 32'h0000_0008);
    wb(1'b1, `EDX_ADR_DIVIDE, 32'h0000_0007);
    wb(1'b1, `EDX_ADR_DIVIDE, 32'h0000_0202);
    wb(1'b0, `EDX_ADR_DIVIDE, 32'h0);
    `CHK(rd, 32'h0000_0008)
    wb(1'b1, `EDX_ADR_CTRL, 32'h0000_0000);
    pat <= 1'b1;
    @(posedge clk_i);
    pat <= 1'b0;
    repeat (5) @(posedge clk_i);
    watch(80, 3);
    `CHK(ri, 10)
    `CHK(hi, 40)
    wb(1'b1, `EDX_ADR_CTRL, 32'h0000_0010);
    fork
      repeat (4)
      begin
        pat <= 1'b1;
        @(posedge clk_i);
        pat <= 1'b0;
        repeat (511) @(posedge clk_i);
      end
      watch(2048, 3);
    join
    `CHK(ri, 4)
    // Length 40 scales to 520, so the marker repeats every 8320 bits
    wb(1'b1, `EDX_ADR_PATLEN, 32'h0000_0028);
    wb(1'b1, `EDX_ADR_MARK_LO, 32'h0000_0029);
    pat <= 1'b1;
    @(posedge clk_i);
    pat <= 1'b0;
    watch(8400, 3);
    `CHK(ri, 2)
    conclude();
  end
endmodule : tb_edx_aux_io
bind edx_aux_io edx_aux_io_assertions chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .aux_in_i(aux_in_i),
  .aux_out_o(aux_out_o), .sync_ok_i(sync_ok_i), .bit_err_i(bit_err_i),
  .data_valid_o(data_valid_o), .meas_en_o(meas_en_o), .cap_start_o(cap_start_o));

// *** verilog/edx_aux_io.sv ***
// Auxiliary timing input and output logic of the bit-error detector
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "edx_regs.svh"
module edx_aux_io
  import edx_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Auxiliary pins
  input wire logic aux_in_i,
  output logic aux_out_o,
  // Detector core
  input wire logic pat_start_i,
  input wire logic sync_ok_i,
  input wire logic bit_err_i,
  output logic data_valid_o,
  output logic meas_en_o,
  output logic cap_start_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Short patterns are repeated until they reach the minimum length
  function automatic logic [36:0] scale_len(input logic [36:0] len, input logic [36:0] floor_v);
    logic [36:0] r;
    r = len;
    if (len == '0)
    begin
      r = floor_v;
    end
    else if (len < floor_v)
    begin
      r = ((floor_v + len - 37'h0_0000_0001) / len) * len;
    end
    return r;
  endfunction : scale_len

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] ctrl_q;
  logic [31:0] window_q;
  logic [9:0] divide_q;
  logic [36:0] mark_q;
  logic [31:0] patlen_q;
  logic [31:0] win_wdat;
  logic [31:0] div_wdat;
  logic [31:0] mhi_wdat;
  logic wr_en;
  logic rd_ack;
  edx_wb_state_t wb_state_q;

  edx_in_fn_t in_fn;
  edx_out_fn_t out_fn;
  logic dual;

  assign in_fn = edx_in_fn_t'(ctrl_q[`EDX_CTRL_IN_LSB +: 2]); // R18
  assign out_fn = edx_out_fn_t'(ctrl_q[`EDX_CTRL_OUT_LSB +: 2]); // R18
  assign dual = ctrl_q[`EDX_CTRL_DUAL_BIT];
  assign win_wdat = merge(window_q, wb_dat_i, wb_sel_i);
  assign div_wdat = merge({22'h000000, divide_q}, wb_dat_i, wb_sel_i);
  assign mhi_wdat = merge({27'h0000000, mark_q[36:32]}, wb_dat_i, wb_sel_i);

  // Writes land on the edge where the master samples ack, not before
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && (wb_state_q == EDX_WB_ACK);

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_state_q <= EDX_WB_IDLE;
    end
    else
    begin
      case (wb_state_q)
        EDX_WB_IDLE:
        begin
          if (wb_cyc_i && wb_stb_i)
          begin
            wb_state_q <= EDX_WB_ACK;
          end
        end
        EDX_WB_ACK: wb_state_q <= EDX_WB_IDLE;
        default: wb_state_q <= EDX_WB_IDLE;
      endcase
    end
  end

  assign wb_ack_o = (wb_state_q == EDX_WB_ACK);
  assign rd_ack = wb_cyc_i && wb_stb_i && (wb_state_q == EDX_WB_IDLE);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= `EDX_CTRL_RST;
      window_q <= `EDX_WINDOW_MIN;
      divide_q <= `EDX_DIVIDE_RST;
      mark_q <= `EDX_MARK_RST;
      patlen_q <= `EDX_PATLEN_RST;
    end
    else if (wr_en)
    begin
      case (wb_adr_i)
        `EDX_ADR_CTRL: ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0733;
        `EDX_ADR_WINDOW:
        begin
          // Out of range or off-step values are ignored
          if (win_wdat >= `EDX_WINDOW_MIN && win_wdat <= `EDX_WINDOW_MAX &&
              (win_wdat & `EDX_WINDOW_STEP_MASK) == 32'h0000_0000) // R16
          begin
            window_q <= win_wdat;
          end
        end
        `EDX_ADR_DIVIDE:
        begin
          if (div_wdat[31:10] == 22'h000000 && !div_wdat[0] &&
              div_wdat[9:0] >= `EDX_DIVIDE_MIN && div_wdat[9:0] <= `EDX_DIVIDE_MAX) // R7
          begin
            divide_q <= div_wdat[9:0];
          end
        end
        `EDX_ADR_MARK_LO: mark_q[31:0] <= merge(mark_q[31:0], wb_dat_i, wb_sel_i);
        `EDX_ADR_MARK_HI: mark_q[36:32] <= mhi_wdat[4:0];
        `EDX_ADR_PATLEN: patlen_q <= merge(patlen_q, wb_dat_i, wb_sel_i);
        default: patlen_q <= patlen_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchroniser and input functions

  logic aux_meta_q;
  logic aux_sync_q;
  logic aux_prev_q;
  logic aux_rise;
  logic [31:0] win_cnt_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aux_meta_q <= 1'b0;
      aux_sync_q <= 1'b0;
      aux_prev_q <= 1'b0;
    end
    else
    begin
      aux_meta_q <= aux_in_i;
      aux_sync_q <= aux_meta_q;
      aux_prev_q <= aux_sync_q;
    end
  end

  assign aux_rise = aux_sync_q && !aux_prev_q;

  // Edge during an open window restarts it; the source must leave a gap
  always_ff @(posedge clk_i)
  begin
    if (rst_i || in_fn != EDX_IN_TRIGGER)
    begin
      win_cnt_q <= 32'h0000_0000;
    end
    else if (aux_rise) // R2 R17
    begin
      win_cnt_q <= window_q;
    end
    else if (win_cnt_q != 32'h0000_0000)
    begin
      win_cnt_q <= win_cnt_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      data_valid_o <= 1'b0;
      meas_en_o <= 1'b1;
      cap_start_o <= 1'b0;
    end
    else
    begin
      case (in_fn) // R1 R18
        EDX_IN_TRIGGER: data_valid_o <= aux_rise || (win_cnt_q > 32'h0000_0001); // R2
        EDX_IN_LEVEL: data_valid_o <= aux_sync_q; // R3
        default: data_valid_o <= 1'b1;
      endcase
      meas_en_o <= !(in_fn == EDX_IN_MASK && !aux_sync_q); // R4
      cap_start_o <= (in_fn == EDX_IN_CAPTURE) && ctrl_q[`EDX_CTRL_CAPEXT_BIT] && aux_rise; // R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Marker period and position

  logic [36:0] eff_len_q;
  logic [36:0] period_q;
  logic [36:0] mark_pos_q;
  logic [36:0] bit_cnt_q;
  logic [36:0] step_mask;
  logic marker_q;

  assign step_mask = dual ? 37'h0_0000_000F : 37'h0_0000_0007;

  // Period is LCM(length, 128): length times 128 over its power-of-two factor
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      eff_len_q <= `EDX_MIN_PAT_SINGLE;
      period_q <= `EDX_MIN_PAT_SINGLE;
      mark_pos_q <= `EDX_MARK_RST;
    end
    else
    begin
      eff_len_q <= scale_len({5'h00, patlen_q},
                             dual ? `EDX_MIN_PAT_DUAL : `EDX_MIN_PAT_SINGLE); // R12 R13
      if (eff_len_q[6:0] == 7'h00)
      begin
        period_q <= eff_len_q;
      end
      else
      begin
        period_q <= eff_len_q << (7 - $countones(eff_len_q[6:0] ^ (eff_len_q[6:0] - 7'h01)) + 1);
      end
      if (ctrl_q[`EDX_CTRL_MIXED_BIT])
      begin
        mark_pos_q <= `EDX_MARK_RST; // R11
      end
      else if (dual)
      begin
        mark_pos_q <= (mark_q > period_q - `EDX_MARK_SUB_DUAL || mark_q > `EDX_MARK_MAX_DUAL)
                      ? `EDX_MARK_RST : (mark_q & ~step_mask) | `EDX_MARK_RST; // R10
      end
      else
      begin
        mark_pos_q <= (mark_q > period_q - `EDX_MARK_SUB_SINGLE ||
                       mark_q > {1'b0, `EDX_MARK_MAX_SINGLE})
                      ? `EDX_MARK_RST : (mark_q & ~step_mask) | `EDX_MARK_RST; // R9
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || pat_start_i)
    begin
      bit_cnt_q <= `EDX_MARK_RST;
    end
    else if (bit_cnt_q >= period_q)
    begin
      bit_cnt_q <= `EDX_MARK_RST;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + `EDX_MARK_RST;
    end
  end

  // Mixed patterns hold the marker high over the whole block period
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      marker_q <= 1'b0;
    end
    else if (ctrl_q[`EDX_CTRL_MIXED_BIT])
    begin
      marker_q <= 1'b1; // R11
    end
    else
    begin
      marker_q <= (bit_cnt_q == mark_pos_q); // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output selection

  logic div_clk;

  edx_divclk #(
    .DIV_W(10)
  ) u_divclk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ratio_i(divide_q),
    .align_i(pat_start_i),
    .clk_o(div_clk)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aux_out_o <= 1'b0;
    end
    else
    begin
      case (out_fn) // R18
        EDX_OUT_DIVCLK: aux_out_o <= div_clk; // R6
        EDX_OUT_MARKER: aux_out_o <= marker_q; // R8
        EDX_OUT_SYNC: aux_out_o <= sync_ok_i; // R14
        EDX_OUT_ERROR: aux_out_o <= bit_err_i; // R15
        default: aux_out_o <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (rd_ack)
    begin
      case (wb_adr_i)
        `EDX_ADR_CTRL: wb_dat_o <= ctrl_q;
        `EDX_ADR_WINDOW: wb_dat_o <= window_q;
        `EDX_ADR_DIVIDE: wb_dat_o <= {22'h000000, divide_q};
        `EDX_ADR_MARK_LO: wb_dat_o <= mark_q[31:0];
        `EDX_ADR_MARK_HI: wb_dat_o <= {27'h0000000, mark_q[36:32]};
        `EDX_ADR_PATLEN: wb_dat_o <= patlen_q;
        `EDX_ADR_STATUS: wb_dat_o <= {26'h0000000, aux_out_o, data_valid_o, meas_en_o,
                                      sync_ok_i, bit_err_i, aux_sync_q};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule : edx_aux_io

// *** verilog/edx_divclk.sv ***
// Pattern-locked divided clock generator
`timescale 1ns/1ps
module edx_divclk
  import edx_pkg::*;
#(
  parameter int DIV_W = 10
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic [DIV_W-1:0] ratio_i,
  input wire logic align_i,
  // Output
  output logic clk_o
);

  initial
  begin
    if (DIV_W < 10)
    begin
      $error("edx_divclk: DIV_W too small for ratio 512");
    end
  end

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] half;

  assign half = ratio_i >> 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Count restarts on the pattern start so phase follows the pattern
  always_ff @(posedge clk_i)
  begin
    if (rst_i || align_i) // R6
    begin
      cnt_q <= '0;
    end
    else if (cnt_q == ratio_i - DIV_W'(1))
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_q + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || align_i)
    begin
      clk_o <= 1'b1;
    end
    else
    begin
      clk_o <= (cnt_q + DIV_W'(1) < half) || (cnt_q == ratio_i - DIV_W'(1)); // R6
    end
  end

endmodule : edx_divclk
